// File: sfpc_defines.svh
// Register offsets, field positions, reset values and fixed codes
`ifndef SFPC_DEFINES_SVH
`define SFPC_DEFINES_SVH

// ===========================================================
// Register map
`define SFPC_ADDR_SRC       8'h01
`define SFPC_ADDR_OUT       8'h02
`define SFPC_RST_SRC        8'h20
`define SFPC_RST_OUT        8'h00
`define SFPC_MASK_SRC       8'h3f
`define SFPC_MASK_OUT       8'h11

// ===========================================================
// Field positions
`define SFPC_BIT_WM_MODE    5
`define SFPC_BIT_RESUME     4
`define SFPC_BIT_HIRES      3
`define SFPC_BIT_TS_SUB     2
`define SFPC_BIT_GYRO_EN    1
`define SFPC_BIT_ACCEL_EN   0
`define SFPC_BIT_EMPTY_DIS  4
`define SFPC_BIT_OSC_DIS    0

// ===========================================================
// Fixed data values
`define SFPC_EMPTY_BYTE     8'hff

`endif

// File: sfpc_pkg.sv
// Shared types of the sensor queue configuration block
package sfpc_pkg;
	typedef logic [7:0]  sfpc_byte_t;
	typedef logic [11:0] sfpc_count_t;
	typedef logic [15:0] sfpc_stamp_t;
	typedef enum logic {SFPC_RD_IDLE, SFPC_RD_BURST} sfpc_rd_state_t;
endpackage : sfpc_pkg

// File: sfpc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module sfpc_pin_sync (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// ===========================================================
	// Sync chain; level moves only when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_out <= s3_reg;
			end
		end
	end
endmodule : sfpc_pin_sync

// File: sfpc_fifo_config.sv
// Sensor queue packet and read configuration logic
`timescale 1ns/100ps
`include "sfpc_defines.svh"
module sfpc_fifo_config
	import sfpc_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  rst,
	input  wire logic  [7:0] reg_addr,
	input  wire logic  [7:0] reg_wdata,
	input  wire logic  reg_wr,
	input  wire logic  reg_rd,
	output sfpc_byte_t reg_rdata,
	input  wire logic  [11:0] fill_count,
	input  wire logic  [11:0] watermark_level,
	input  wire logic  output_data_rate_tick,
	output logic       watermark_irq,
	input  wire logic  gyro_pkt_valid,
	input  wire logic  accel_pkt_valid,
	output logic       gyro_pkt_write,
	output logic       accel_pkt_write,
	output logic       high_resolution_pkt,
	input  wire logic  [15:0] packet_time_stamp,
	input  wire logic  [15:0] frame_sync_stamp,
	input  wire logic  stamp_unit_sync_enable,
	input  wire logic  frame_sync_input,
	output sfpc_stamp_t stamp_out,
	output logic       stamp_substituted,
	input  wire logic  host_rd,
	input  wire logic  host_rd_done,
	input  wire logic  queue_empty,
	input  wire logic  [7:0] queue_byte,
	input  wire logic  [5:0] packet_len,
	output sfpc_byte_t host_rd_data,
	output sfpc_count_t rd_ptr,
	output sfpc_count_t head_ptr
);
	sfpc_byte_t     src_reg;
	sfpc_byte_t     out_reg;
	logic           eq_reg;
	logic           fs_level_reg;
	logic           fs_pend_reg;
	logic           fs_level;
	logic [5:0]     pkt_cnt_reg;
	sfpc_rd_state_t state_reg;

	// ===========================================================
	// Register decode and field views
	wire wr_src      = reg_wr && (reg_addr == `SFPC_ADDR_SRC);
	wire wr_out      = reg_wr && (reg_addr == `SFPC_ADDR_OUT);
	wire wm_mode     = src_reg[`SFPC_BIT_WM_MODE];
	wire resume_en   = src_reg[`SFPC_BIT_RESUME];
	wire ts_sub_en   = src_reg[`SFPC_BIT_TS_SUB];
	wire gyro_en     = src_reg[`SFPC_BIT_GYRO_EN];
	wire accel_en    = src_reg[`SFPC_BIT_ACCEL_EN];
	wire empty_dis   = out_reg[`SFPC_BIT_EMPTY_DIS];
	wire [7:0] rd_mux = (reg_addr == `SFPC_ADDR_SRC) ? src_reg :
	                    (reg_addr == `SFPC_ADDR_OUT) ? out_reg : 8'h00;

	// Writes keep only defined bits; reserved bits stay zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			src_reg   <= `SFPC_RST_SRC;
			out_reg   <= `SFPC_RST_OUT;
			reg_rdata <= 8'h00;
		end else begin
			if (wr_src) src_reg <= reg_wdata & `SFPC_MASK_SRC;
			if (wr_out) out_reg <= reg_wdata & `SFPC_MASK_OUT;
			if (reg_rd) reg_rdata <= rd_mux;
		end
	end

	// ===========================================================
	// Watermark interrupt
	wire wm_eq   = (fill_count == watermark_level);
	wire wm_ge   = (fill_count >= watermark_level);
	wire wm_fire = wm_mode ? (output_data_rate_tick && wm_ge)
	                       : (wm_eq && !eq_reg);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			eq_reg        <= 1'b0;
			watermark_irq <= 1'b0;
		end else begin
			eq_reg        <= wm_eq;
			watermark_irq <= wm_fire;
		end
	end

	// ===========================================================
	// Packet admission and resolution
	assign high_resolution_pkt = src_reg[`SFPC_BIT_HIRES];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gyro_pkt_write  <= 1'b0;
			accel_pkt_write <= 1'b0;
		end else begin
			gyro_pkt_write  <= gyro_pkt_valid && gyro_en;
			accel_pkt_write <= accel_pkt_valid && accel_en;
		end
	end

	// ===========================================================
	// Frame-sync stamp substitution
	sfpc_pin_sync u_frame_sync (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin_in    (frame_sync_input),
		.level_out (fs_level)
	);

	wire fs_rise  = fs_level && !fs_level_reg;
	wire pkt_any  = (gyro_pkt_valid && gyro_en) || (accel_pkt_valid && accel_en);
	wire sub_ok   = ts_sub_en && stamp_unit_sync_enable;
	wire do_sub   = pkt_any && sub_ok && fs_pend_reg;

	// Pending event: a new edge wins over the clear by a packet
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fs_level_reg      <= 1'b0;
			fs_pend_reg       <= 1'b0;
			stamp_out         <= 16'h0000;
			stamp_substituted <= 1'b0;
		end else begin
			fs_level_reg <= fs_level;
			if (fs_rise) fs_pend_reg <= 1'b1;
			else if (do_sub) fs_pend_reg <= 1'b0;
			if (pkt_any) begin
				stamp_out         <= do_sub ? frame_sync_stamp : packet_time_stamp;
				stamp_substituted <= do_sub;
			end
		end
	end

	// ===========================================================
	// Host read pointer tracking
	wire       take     = host_rd && !queue_empty;
	wire [5:0] cnt_inc  = pkt_cnt_reg + 6'h01;
	wire       pkt_end  = take && (cnt_inc == packet_len);
	wire [11:0] rd_step = take ? (rd_ptr + 12'h001) : rd_ptr;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_ptr      <= 12'h000;
			head_ptr    <= 12'h000;
			pkt_cnt_reg <= 6'h00;
			state_reg   <= SFPC_RD_IDLE;
		end else begin
			case (state_reg)
			SFPC_RD_IDLE: begin
				if (take && !host_rd_done) state_reg <= SFPC_RD_BURST;
			end
			SFPC_RD_BURST: begin
				if (host_rd_done) state_reg <= SFPC_RD_IDLE;
			end
			default: state_reg <= SFPC_RD_IDLE;
			endcase
			if (host_rd_done && resume_en) begin
				rd_ptr      <= rd_step;
				head_ptr    <= rd_step;
				pkt_cnt_reg <= pkt_end ? 6'h00 : (take ? cnt_inc : pkt_cnt_reg);
			end else if (host_rd_done) begin
				rd_ptr      <= pkt_end ? rd_step : head_ptr;
				head_ptr    <= pkt_end ? rd_step : head_ptr;
				pkt_cnt_reg <= 6'h00;
			end else begin
				rd_ptr <= rd_step;
				if (pkt_end) begin
					head_ptr    <= rd_step;
					pkt_cnt_reg <= 6'h00;
				end else if (take) begin
					pkt_cnt_reg <= cnt_inc;
				end
			end
		end
	end

	// Read data: marker byte or held last byte when empty
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			host_rd_data <= 8'h00;
		end else if (take) begin
			host_rd_data <= queue_byte;
		end else if (host_rd && !empty_dis) begin
			host_rd_data <= `SFPC_EMPTY_BYTE;
		end
	end

	// ===========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_wm_tick_mode: assert property (
		(wm_mode && output_data_rate_tick && wm_ge) |=> watermark_irq)
		else $error("Tick mode watermark missed");
	a_wm_equal_mode: assert property (
		(!wm_mode && $changed(fill_count) && wm_eq && !$past(wm_eq)
		 && !$past(wm_mode)) |=> watermark_irq)
		else $error("Equal mode watermark missed");
	a_wm_no_spurious: assert property (
		(watermark_irq && !$past(wm_mode)) |-> $past(wm_eq))
		else $error("Watermark raised without equality");
	a_gyro_gate: assert property (
		gyro_pkt_write |-> $past(gyro_en && gyro_pkt_valid))
		else $error("Rotation packet written while disabled");
	a_accel_gate: assert property (
		accel_pkt_write |-> $past(accel_en && accel_pkt_valid))
		else $error("Acceleration packet written while disabled");
	a_hires_follow: assert property (
		wr_src |=> high_resolution_pkt == $past(reg_wdata[3]))
		else $error("High resolution bit not applied");
	// Only a freshly admitted packet is judged; the flag holds afterwards
	a_stamp_sub: assert property (
		(stamp_substituted && (gyro_pkt_write || accel_pkt_write)) |->
		$past(ts_sub_en && stamp_unit_sync_enable))
		else $error("Stamp substituted without both enables");
	a_read_rewind: assert property (
		(host_rd_done && !resume_en && !host_rd) |=> rd_ptr == head_ptr)
		else $error("Stopped read did not rewind");
	a_read_resume: assert property (
		(host_rd_done && resume_en && !host_rd) |=>
		(rd_ptr == $past(rd_ptr)) && (head_ptr == $past(rd_ptr)))
		else $error("Resumed read lost its position");
	a_empty_marker: assert property (
		(host_rd && queue_empty && !empty_dis) |=> host_rd_data == 8'hff)
		else $error("Empty read did not return marker");
	a_reserved_zero: assert property (
		(reg_rd && reg_addr == `SFPC_ADDR_SRC) |=> reg_rdata[7:6] == 2'b00)
		else $error("Reserved bits read non-zero");

	c_tick_irq: cover property (wm_mode ##1 watermark_irq ##2 watermark_irq);
	c_rewind: cover property (take ##1 host_rd_done && !resume_en);
	c_substitute: cover property (stamp_substituted);
	c_empty_read: cover property (host_rd && queue_empty);
endmodule : sfpc_fifo_config

// File: sfpc_host_model.sv
// Host model driving the register port and the queue read port
`timescale 1ns/100ps
module sfpc_host_model (
	input  wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic       host_rd,
	output logic       host_rd_done
);
	int pos = 0; // Byte position inside the current packet
	initial begin
		{reg_addr, reg_wdata} = 16'h0000;
		{reg_wr, reg_rd, host_rd, host_rd_done} = 4'h0;
	end
	// One register access; idle address and data lines show the inverse value
	task automatic reg_acc(input logic w, input logic [7:0] a, d);
		@(negedge sys_clk);
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
		@(negedge sys_clk);
		{reg_wr, reg_rd} = 2'b00;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : reg_acc
	// Byte reads then an end of burst pulse
	task automatic burst(input int n, input int len);
		repeat (n) begin
			@(negedge sys_clk);
			host_rd = 1'b1;
			pos = (pos + 1) % len; // Frame position
		end
		@(negedge sys_clk);
		{host_rd, host_rd_done} = 2'b01;
		@(negedge sys_clk);
		host_rd_done = 1'b0;
	endtask : burst
endmodule : sfpc_host_model

// File: sfpc_fifo_config_tb_top.sv
// Self-checking bench of the sensor queue configuration block
`timescale 1ns/100ps
module sfpc_fifo_config_tb_top;
	import sfpc_pkg::*;
	logic        sys_clk = 1'b0, rst = 1'b1;
	logic [7:0]  reg_addr, reg_wdata, queue_byte;
	logic        reg_wr, reg_rd, host_rd, host_rd_done;
	sfpc_byte_t  reg_rdata, host_rd_data;
	logic [11:0] fill_count = '0, watermark_level = '0;
	logic        tick = 1'b0, irq, gyro_v = 1'b0, accel_v = 1'b0;
	logic        gyro_w, accel_w, hires, sub, fs_pin = 1'b0;
	logic        sync_en = 1'b0, queue_empty = 1'b0;
	logic [15:0] pts = '0, fts = '0;
	logic [5:0]  packet_len = 6'h04;
	sfpc_stamp_t stamp;
	sfpc_count_t rd_ptr, head_ptr;
	logic [16:0] exp_q[5][$];
	logic        rdp = 1'b0, hrp = 1'b0;
	int          err_total = 0, n_compared = 0, cyc = 0;
	logic [31:0] seed = 32'd66;

	always #5 sys_clk = ~sys_clk;
	assign queue_byte = qb(rd_ptr);

	sfpc_fifo_config dut_u (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fill_count(fill_count),
		.watermark_level(watermark_level), .output_data_rate_tick(tick),
		.watermark_irq(irq), .gyro_pkt_valid(gyro_v),
		.accel_pkt_valid(accel_v), .gyro_pkt_write(gyro_w),
		.accel_pkt_write(accel_w), .high_resolution_pkt(hires),
		.packet_time_stamp(pts), .frame_sync_stamp(fts),
		.stamp_unit_sync_enable(sync_en), .frame_sync_input(fs_pin),
		.stamp_out(stamp), .stamp_substituted(sub), .host_rd(host_rd),
		.host_rd_done(host_rd_done), .queue_empty(queue_empty),
		.queue_byte(queue_byte), .packet_len(packet_len),
		.host_rd_data(host_rd_data), .rd_ptr(rd_ptr), .head_ptr(head_ptr));

	sfpc_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.host_rd(host_rd), .host_rd_done(host_rd_done));

	// ===========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] qb(input logic [11:0] a);
		return (a[7:0] * 8'h1d) ^ 8'h5a;
	endfunction : qb
	task automatic chk(input string nm, input logic [16:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic take(input int k, input string nm, input logic [16:0] s);
		if (exp_q[k].size() == 0) chk(nm, s, 17'h1ffff);
		else chk(nm, s, exp_q[k].pop_front());
	endtask : take
	task automatic wr(input logic [7:0] a, d);
		host_u.reg_acc(1'b1, a, d);
	endtask : wr
	task automatic rd_reg(input logic [7:0] a, e);
		exp_q[0].push_back({9'h0, e});
		host_u.reg_acc(1'b0, a, 8'h00);
	endtask : rd_reg
	task automatic rd_q(input int n, input logic [11:0] a0);
		for (int i = 0; i < n; i++) exp_q[1].push_back({9'h0, qb(a0 + i)});
		host_u.burst(n, 4);
	endtask : rd_q
	task automatic end_sim();
		foreach (exp_q[k]) if (exp_q[k].size() != 0) chk("left", 1, 0);
		if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// ===========================================================
	// Monitor: oldest note of a kind against each result seen
	always @(posedge sys_clk) begin
		if (rdp) take(0, "reg_rdata", 17'(reg_rdata));
		if (hrp) take(1, "host_rd_data", 17'(host_rd_data));
		if (irq === 1'b1) take(2, "watermark_irq", 17'h1);
		if (gyro_w === 1'b1) take(3, "gyro", {sub, stamp});
		if (accel_w === 1'b1) take(4, "accel", {sub, stamp});
		rdp <= reg_rd;
		hrp <= host_rd;
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			end_sim();
		end
	end

	// ===========================================================
	// Stimulus
	initial begin
		logic s;
		logic [16:0] e;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		// Reset values, unmapped place, reserved bits
		rd_reg(8'h01, 8'h20);
		rd_reg(8'h02, 8'h00);
		rd_reg(8'h07, 8'h00);
		wr(8'h01, 8'hff);
		wr(8'h02, 8'hff);
		rd_reg(8'h01, 8'h3f);
		rd_reg(8'h02, 8'h11);
		// Source enables, resolution and stamp substitution
		for (int i = 0; i < 32; i++) begin
			wr(8'h01, {4'h0, i[3:0]});
			@(negedge sys_clk);
			chk("hires", {16'h0, hires}, {16'h0, i[3]});
			sync_en = i[4];
			fs_pin = 1'b1;
			repeat (4) @(negedge sys_clk);
			fs_pin = 1'b0;
			repeat (6) @(negedge sys_clk);
			{pts, fts} = rnd();
			{gyro_v, accel_v} = 2'b11;
			s = i[2] & i[4];
			e = {s, s ? fts : pts};
			if (i[1]) exp_q[3].push_back(e);
			if (i[0]) exp_q[4].push_back(e);
			@(negedge sys_clk);
			{gyro_v, accel_v} = 2'b00;
		end
		// Watermark on entering equality, then on ticks
		e = 17'(rnd());
		watermark_level = {1'b0, e[10:0]} + 12'h001;
		for (int j = 0; j < 5; j++) begin
			fill_count = watermark_level + (j == 3) - (j == 0);
			if (j == 1 || j == 4) exp_q[2].push_back(17'h1);
			@(negedge sys_clk);
		end
		fill_count = '0;
		wr(8'h01, 8'h20);
		for (int j = 0; j < 3; j++) begin
			fill_count = watermark_level + 12'(j) - 12'h001;
			@(negedge sys_clk);
			tick = 1'b1;
			if (j > 0) exp_q[2].push_back(17'h1);
			@(negedge sys_clk);
			tick = 1'b0;
		end
		// Stopped reads restart at the unread packet
		rd_q(2, 12'h000);
		rd_q(4, 12'h000);
		rd_q(3, 12'h004);
		// Partial reads resume after the last byte; host joins from a frame start
		wr(8'h01, 8'h10);
		host_u.pos = 0;
		rd_q(1, 12'h004);
		rd_q(2, 12'h005);
		chk("head_ptr", 17'(head_ptr), 17'h00007);
		chk("frame_pos", 17'(rd_ptr[1:0]), 17'(host_u.pos));
		// Empty queue: last byte held, then the marker
		queue_empty = 1'b1;
		exp_q[1].push_back({9'h0, qb(12'h006)});
		host_u.burst(1, 4);
		wr(8'h02, 8'h00);
		exp_q[1].push_back(17'h000ff);
		host_u.burst(1, 4);
		repeat (3) @(negedge sys_clk);
		end_sim();
	end
endmodule : sfpc_fifo_config_tb_top
